// ### inc/cid_params.svh
// Constants for the caller-identity function-select decoder
`ifndef CID_PARAMS_SVH
`define CID_PARAMS_SVH
`define CID_CLK_HZ 25000000
`define CID_BAUD 1200
`define CID_HALF_BIT_CYC ((`CID_CLK_HZ) / (2 * `CID_BAUD))
`define CID_HALF_BIT_W 14
`define CID_RESET_MODE 1'b1
`endif

// ### inc/cid_pkg.sv
// Types for the caller-identity function-select decoder
package cid_pkg;
	typedef enum logic [2:0] {
		CID_FSK,
		CID_TONE_HYBRID,
		CID_TONE_LINE,
		CID_POWER_DOWN,
		CID_FACTORY_TEST
	} cid_func_e;

	typedef struct packed {
		logic fsk_enable;
		logic tone_enable;
		logic sel_hybrid;
		logic iface_mode1;
		logic powered;
	} cid_ctrl_s;
endpackage

// ### hw/cid_mode_decoder.sv
// Function-select decoder and shared ready/steering output of the caller-identity receiver
`timescale 1ns/1ps
`default_nettype none
`include "cid_params.svh"
module cid_mode_decoder
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Control pins from the host
	input wire logic interface_select_pin_i,
	input wire logic function_select_upper_i,
	input wire logic function_select_lower_i,
	// Events from the demodulator and tone detector
	input wire logic word_end_i,
	input wire logic tone_qualified_i,
	// Decoded controls and shared output
	output var cid_pkg::cid_ctrl_s ctrl_o,
	output var cid_pkg::cid_func_e func_o,
	output logic shared_ready_steer_n_o
);
	cid_pkg::cid_func_e next_func;
	cid_pkg::cid_ctrl_s next_ctrl;
	cid_pkg::cid_func_e func;
	cid_pkg::cid_ctrl_s ctrl;
	logic [`CID_HALF_BIT_W-1:0] half_bit_cnt;
	logic word_ready_n;
	logic delayed_steering_n;

	// Pin decode; pins are static straps so a registered copy costs one cycle only
	always_comb
	begin
		next_func = cid_pkg::CID_FACTORY_TEST;
		if (function_select_upper_i && function_select_lower_i)
			next_func = cid_pkg::CID_FSK;
		else if (function_select_upper_i)
			next_func = cid_pkg::CID_TONE_HYBRID;
		else if (function_select_lower_i)
			next_func = cid_pkg::CID_TONE_LINE;
		else if (interface_select_pin_i)
			next_func = cid_pkg::CID_POWER_DOWN;
	end

	// Section enables follow the function; factory test enables nothing
	always_comb
	begin
		next_ctrl = '0;
		next_ctrl.iface_mode1 = interface_select_pin_i;
		case (next_func)
			cid_pkg::CID_FSK:
			begin
				next_ctrl.fsk_enable = 1'b1;
				next_ctrl.powered = 1'b1;
			end
			cid_pkg::CID_TONE_HYBRID:
			begin
				next_ctrl.tone_enable = 1'b1;
				next_ctrl.sel_hybrid = 1'b1;
				next_ctrl.powered = 1'b1;
			end
			cid_pkg::CID_TONE_LINE:
			begin
				next_ctrl.tone_enable = 1'b1;
				next_ctrl.powered = 1'b1;
			end
			default:
			begin
				next_ctrl.powered = 1'b0;
			end
		endcase
	end

	// Registered function and controls
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			func <= cid_pkg::CID_POWER_DOWN;
			ctrl <= '0;
		end
		else
		begin
			func <= next_func;
			ctrl <= next_ctrl;
		end
	end

	// Word-ready half-bit pulse; a word end during a pulse restarts it
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			half_bit_cnt <= '0;
		else if (!ctrl.fsk_enable)
			half_bit_cnt <= '0;
		else if (word_end_i)
			half_bit_cnt <= `CID_HALF_BIT_W'(`CID_HALF_BIT_CYC);
		else if (half_bit_cnt != '0)
			half_bit_cnt <= half_bit_cnt - 1'b1;
	end

	assign word_ready_n = (half_bit_cnt == '0);
	assign delayed_steering_n = ~(ctrl.tone_enable & tone_qualified_i);

	// Shared output from a flip-flop; rests high outside FSK and tone modes
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			shared_ready_steer_n_o <= 1'b1;
		else if (ctrl.fsk_enable)
			shared_ready_steer_n_o <= word_ready_n;
		else if (ctrl.tone_enable)
			shared_ready_steer_n_o <= delayed_steering_n;
		else
			shared_ready_steer_n_o <= 1'b1;
	end

	assign ctrl_o = ctrl;
	assign func_o = func;

	fsk_decode_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(function_select_upper_i && function_select_lower_i) |=> (ctrl.fsk_enable && !ctrl.tone_enable))
		else $error("FSK pattern did not enable demodulator only");
	hybrid_decode_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(function_select_upper_i && !function_select_lower_i) |=> (ctrl.tone_enable && ctrl.sel_hybrid))
		else $error("Hybrid tone pattern not decoded");
	line_decode_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(!function_select_upper_i && function_select_lower_i) |=> (ctrl.tone_enable && !ctrl.sel_hybrid))
		else $error("Line tone pattern not decoded");
	power_down_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(interface_select_pin_i && !function_select_upper_i && !function_select_lower_i)
		|=> (!ctrl.powered && func == cid_pkg::CID_POWER_DOWN))
		else $error("Power-down pattern left device powered");
	iface_mode_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		1'b1 |=> (ctrl.iface_mode1 == $past(interface_select_pin_i)))
		else $error("Interface mode does not follow select pin");
	ready_pulse_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(ctrl.fsk_enable && word_end_i && $stable(ctrl.fsk_enable)) ##1 ctrl.fsk_enable
		|-> ##1 !shared_ready_steer_n_o)
		else $error("Word-ready did not go low after word end");
	steer_low_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(ctrl.tone_enable && tone_qualified_i) |=> (ctrl.tone_enable |-> !shared_ready_steer_n_o))
		else $error("Steering output not low on qualified tone");
	exclusive_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		!(ctrl.fsk_enable && ctrl.tone_enable))
		else $error("FSK and tone sections both powered");

	// Checker helper: length of the current low run of the shared output in FSK mode.
	// A word end clears it, so a restarted pulse is measured from the restart edge.
	// The run is bounded by one more than the half-bit count, so the counter cannot wrap.
	logic [`CID_HALF_BIT_W-1:0] low_run;

	// Low-run counter, cleared outside FSK; a steering low is counted only when it is left over from the last tone cycle
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			low_run <= '0;
		else if (!ctrl.fsk_enable)
			low_run <= '0;
		else if (word_end_i)
			low_run <= '0;
		else if (!shared_ready_steer_n_o)
			low_run <= low_run + 1'b1;
		else
			low_run <= '0;
	end

	// A word end in FSK mode loads the full half-bit count
	cnt_load_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(ctrl.fsk_enable && word_end_i) |=> (half_bit_cnt == `CID_HALF_BIT_W'(`CID_HALF_BIT_CYC)))
		else $error("Half-bit counter not loaded on word end");

	// With no pulse running the word-ready output rests high
	fsk_rest_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(ctrl.fsk_enable && half_bit_cnt == '0) |=> (ctrl.fsk_enable |-> shared_ready_steer_n_o))
		else $error("Word-ready low with no pulse running");

	// The restart edge itself adds one cycle to the measured run, hence the extra one
	pulse_len_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		low_run <= `CID_HALF_BIT_W'(`CID_HALF_BIT_CYC + 1))
		else $error("Word-ready pulse longer than half a bit");

	// Steering returns high once the qualified tone is gone
	steer_release_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(ctrl.tone_enable && !tone_qualified_i) |=> (ctrl.tone_enable |-> shared_ready_steer_n_o))
		else $error("Steering output low without qualified tone");

	// The hybrid amplifier is only ever chosen for tone detection
	hybrid_tone_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		ctrl.sel_hybrid |-> ctrl.tone_enable)
		else $error("Hybrid input selected outside tone detection");

	// Power follows the sections: nothing enabled means the device is down
	powered_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		ctrl.powered == (ctrl.fsk_enable || ctrl.tone_enable))
		else $error("Power flag disagrees with section enables");

	// The test pattern enables nothing, so a stray strap cannot wake a section
	factory_off_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(!interface_select_pin_i && !function_select_upper_i && !function_select_lower_i)
		|=> (!ctrl.powered && func == cid_pkg::CID_FACTORY_TEST))
		else $error("Factory-test pattern enabled a section");

	// Outside FSK and tone modes the shared output is held high
	idle_high_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(!ctrl.fsk_enable && !ctrl.tone_enable) |=> shared_ready_steer_n_o)
		else $error("Shared output low while both sections are off");
endmodule
`default_nettype wire

// ### sim/cid_host_model.sv
// Host controller model that drives the three control pins of the decoder
`timescale 1ns/1ps
`default_nettype none
module cid_host_model
(
	// Function wanted by the bench
	input wire cid_pkg::cid_func_e want_i,
	input wire logic mode1_i,
	// Control pins
	output logic sel_o,
	output logic up_o,
	output logic low_o
);
	// Every pin is driven, since mode 0 FSK together with power down needs all three
	assign sel_o = mode1_i | (want_i == cid_pkg::CID_POWER_DOWN);
	assign up_o = want_i inside {cid_pkg::CID_FSK, cid_pkg::CID_TONE_HYBRID};
	assign low_o = want_i inside {cid_pkg::CID_FSK, cid_pkg::CID_TONE_LINE};
endmodule
`default_nettype wire

// ### sim/callerid_mode_select_decoder_tb.sv
// Self-checking bench for the function-select decoder
`timescale 1ns/1ps
`default_nettype none
module callerid_mode_select_decoder_tb;
	logic clock = 1'b0, rst_n = 1'b0, mode1 = 1'b0, word_end = 1'b0, tone_q = 1'b0, sel, up, low, shared_n;
	cid_pkg::cid_func_e want = cid_pkg::CID_FSK, func;
	cid_pkg::cid_ctrl_s ctrl;
	int errors, check_count, cyc;
	cid_host_model i_cid_host_model (.want_i(want), .mode1_i(mode1), .sel_o(sel), .up_o(up), .low_o(low));
	cid_mode_decoder i_cid_mode_decoder (.clock_i(clock), .rst_n_i(rst_n), .interface_select_pin_i(sel),
		.function_select_upper_i(up), .function_select_lower_i(low), .word_end_i(word_end),
		.tone_qualified_i(tone_q), .ctrl_o(ctrl), .func_o(func), .shared_ready_steer_n_o(shared_n));
	// Clock, and a cycle ceiling well above the two half-bit waits
	initial forever #20 clock = ~clock;
	always @(posedge clock) if (++cyc == 40000) finish_test(1);
	task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
		check_count++;
		errors += int'(got !== exp);
		if (got !== exp)
			$display("[ERR] %s expected %h seen %h", what, exp, got);
	endtask
	task automatic go(input cid_pkg::cid_func_e f, input logic m);
		@(negedge clock) want = f;
		mode1 = m;
		repeat (2) @(negedge clock);
	endtask
	task automatic t_modes();
		for (int i = 0; i < 5; i++)
		begin
			go(cid_pkg::cid_func_e'(i), 1'b0);
			chk("func", 4'(i), 4'(func));
			chk("ctrl", 4'(20'h0_0579 >> 4 * i), {ctrl.fsk_enable, ctrl.tone_enable, ctrl.sel_hybrid, ctrl.powered});
			chk("idle", 4'h1, 4'(shared_n));
			chk("iface0", 4'(i == 3), 4'(ctrl.iface_mode1));
			tone_q = 1'b1;
			repeat (2) @(negedge clock);
			chk("steer", 4'(i != 1 && i != 2), 4'(shared_n));
			tone_q = 1'b0;
		end
		$display("t_modes end");
	endtask
	task automatic t_word();
		go(cid_pkg::CID_FSK, 1'b1);
		chk("iface", 4'h1, 4'(ctrl.iface_mode1));
		word_end = 1'b1;
		@(negedge clock) word_end = 1'b0;
		repeat (5001) @(negedge clock);
		word_end = 1'b1;
		@(negedge clock) word_end = 1'b0;
		repeat (10416) @(negedge clock);
		chk("restart", 4'h0, 4'(shared_n));
		@(negedge clock);
		chk("release", 4'h1, 4'(shared_n));
		$display("t_word end");
	endtask
	task automatic t_alert();
		go(cid_pkg::CID_TONE_HYBRID, 1'b0);
		tone_q = 1'b1;
		repeat (2) @(negedge clock);
		chk("alert", 4'h0, 4'(shared_n));
		tone_q = 1'b0;
		// Host has muted and acknowledged, and now asks for the data
		go(cid_pkg::CID_FSK, 1'b0);
		chk("ack ctrl", 4'h9, {ctrl.fsk_enable, ctrl.tone_enable, ctrl.sel_hybrid, ctrl.powered});
		chk("ack mode", 4'h0, 4'(ctrl.iface_mode1));
		chk("ack idle", 4'h1, 4'(shared_n));
		// Reset in mid-run, then the first edge after release decodes the pins again
		rst_n = 1'b0;
		@(negedge clock);
		chk("rst func", 4'(cid_pkg::CID_POWER_DOWN), 4'(func));
		chk("rst ctrl", 4'h0, {ctrl.fsk_enable, ctrl.tone_enable, ctrl.sel_hybrid, ctrl.powered});
		chk("rst out", 4'h1, 4'(shared_n));
		rst_n = 1'b1;
		@(negedge clock);
		chk("rel ctrl", 4'h9, {ctrl.fsk_enable, ctrl.tone_enable, ctrl.sel_hybrid, ctrl.powered});
		$display("t_alert end");
	endtask
	task automatic finish_test(input int lost);
		errors += lost;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Reset for 16 cycles, then the scenarios
	initial
	begin
		repeat (16) @(negedge clock);
		rst_n = 1'b1;
		t_modes();
		t_word();
		t_alert();
		finish_test(0);
	end
endmodule
`default_nettype wire
